// *** include/sofc_pkg.sv ***
// ==========================================
// Synth output / fast-lock configuration constants
package sofc_pkg;

  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] SOFC_ADDR_WORD   = 8'h00; // Control word entry port
  localparam logic [7:0] SOFC_ADDR_STATUS = 8'h04; // Block state
  localparam logic [7:0] SOFC_ADDR_SEEN   = 8'h08; // Words written since reset
  localparam logic [7:0] SOFC_ADDR_SHADOW = 8'h20; // Readback of word 0, then +4 each

  // ==========================================
  // Control word layout
  localparam int SOFC_NUM_WORDS = 6;  // Words 0..5
  localparam int SOFC_SEL_W     = 3;  // Word select field width
  localparam int SOFC_IDX_FREQ  = 0;  // Integer and fraction word
  localparam int SOFC_IDX_MOD   = 1;  // Modulus word
  localparam int SOFC_IDX_REF   = 2;  // Reference path word
  localparam int SOFC_IDX_CLK   = 3;  // Clock divider word
  localparam int SOFC_IDX_OUT   = 4;  // Output stage control
  localparam int SOFC_IDX_LOCK  = 5;  // Lock pin configuration
  // Word 0
  localparam int SOFC_INT_LSB   = 15;
  localparam int SOFC_INT_W     = 16;
  localparam int SOFC_FRACTION_NUMERATOR_LSB  = 3;
  localparam int SOFC_FRACTION_NUMERATOR_W    = 12;
  // Word 1
  localparam int SOFC_MOD_LSB   = 3;
  localparam int SOFC_MOD_W     = 12;
  // Word 2
  localparam int SOFC_DBL_BIT   = 25;
  localparam int SOFC_HALF_BIT  = 24;
  localparam int SOFC_RCNT_LSB  = 14;
  localparam int SOFC_RCNT_W    = 10;
  // Word 3
  localparam int SOFC_SLIP_BIT  = 18;
  localparam int SOFC_MODE_LSB  = 15;
  localparam int SOFC_MODE_W    = 2;
  localparam int SOFC_CDIV_LSB  = 3;
  localparam int SOFC_CDIV_W    = 12;
  // Word 4
  localparam int SOFC_DIV_LSB   = 20;
  localparam int SOFC_DIV_W     = 3;
  localparam int SOFC_AUXS_BIT  = 9;
  localparam int SOFC_AUXE_BIT  = 8;
  localparam int SOFC_AUXP_LSB  = 6;
  localparam int SOFC_MAINE_BIT = 5;
  localparam int SOFC_MAINP_LSB = 3;
  localparam int SOFC_PWR_W     = 2;
  // Word 5
  localparam int SOFC_LDP_LSB   = 22;
  localparam int SOFC_LDP_W     = 2;

  // ==========================================
  // Status register layout
  localparam int SOFC_ST_WIDE   = 0;  // Wide bandwidth active
  localparam int SOFC_ST_SYNC   = 1;  // Resync timer running
  localparam int SOFC_ST_CELL   = 4;  // Extra pump cell count, 3 bits
  localparam int SOFC_ST_SEL    = 8;  // Last word select, 3 bits

  // ==========================================
  // Bus codes and limits
  localparam logic [1:0] SOFC_HTRANS_NONSEQ = 2'h2;
  localparam logic       SOFC_HRESP_OKAY    = 1'h0;
  localparam logic [2:0] SOFC_SLIP_MAX      = 3'h7; // Extra pump cells at most

  // Clock divider modes
  typedef enum logic [1:0] {
    SOFC_CDIV_OFF    = 2'h0,
    SOFC_CDIV_FAST   = 2'h1,
    SOFC_CDIV_RESYNC = 2'h2
  } sofc_cdiv_mode_t;

  // Slip reduction controller states
  typedef enum logic [2:0] {
    SOFC_SLIP_IDLE    = 3'h1,
    SOFC_SLIP_BOOST   = 3'h2,
    SOFC_SLIP_RELEASE = 3'h4
  } sofc_slip_state_t;

  // Word select from a raw control word
  function automatic logic [SOFC_SEL_W-1:0] sofc_sel(input logic [31:0] w);
    return w[SOFC_SEL_W-1:0];
  endfunction

endpackage

// *** core/sofc_timer.sv ***
`timescale 1ns/1ps
// ==========================================
// Clock divider timer: fast-lock window or periodic resync
module sofc_timer #(
  parameter int unsigned W = 12
) (
  input  logic                     clk,
  input  logic                     rstn,
  input  logic                     load,
  input  sofc_pkg::sofc_cdiv_mode_t mode,
  input  logic [W-1:0]             value,
  input  logic                     tick,
  output logic                     wide_bw,
  output logic                     resync_run,
  output logic                     sync_pulse
);
  import sofc_pkg::*;

  logic [W-1:0] cnt;     // Ticks left in the current period
  logic [W-1:0] period;  // Reload for resync mode
  logic         active;  // Timer running
  logic         rs;      // Running in resync mode
  logic         last;    // Final tick of a period

  assign last       = active && tick && (cnt <= W'(1));
  assign wide_bw    = active && !rs;
  assign resync_run = active && rs;

  // Load on a clock divider word, count comparison ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt    <= '0;
      period <= '0;
      active <= 1'b0;
      rs     <= 1'b0;
    end else if (load) begin
      // Fast-lock or resync starts unless the value is zero; off stops the timer
      cnt    <= value; // R18
      period <= value;
      active <= (mode == SOFC_CDIV_FAST || mode == SOFC_CDIV_RESYNC) && (value != '0); // R21
      rs     <= (mode == SOFC_CDIV_RESYNC); // R21
    end else if (last) begin
      // Period done: reload for resync, end window for fast lock
      cnt    <= period;
      active <= rs; // R19
    end else if (active && tick) begin
      cnt <= cnt - W'(1); // R19
    end
  end

  // One-cycle sync marker at each resync period end, unless a load arrives in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= last && rs && !load; // R21
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_WIDE_HOLD: assert property ( // R19
    wide_bw && !load && !(tick && cnt <= W'(1)) |=> wide_bw)
    else $error("wide bandwidth ended before its tick count");
  AST_WIDE_END: assert property ( // R19
    wide_bw && !load && tick && cnt == W'(1) |=> !wide_bw)
    else $error("wide bandwidth outlived its tick count");

endmodule

// *** core/sofc_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: Aux output chooses divided or raw oscillator
// R2: Aux output enable bit
// R3: Aux output power two-bit field
// R4: Primary output enable bit
// R5: Primary output power two-bit field
// R6: Select pattern 1,0,1 stores lock pin word
// R7: Lock pin behaviour from upper field
// R8: Host writes words five down to zero
// R9: Output rate from integer, fraction, modulus, divider
// R10: Comparison rate from doubler, count, halver
// R11: Host keeps comparison rate under limit
// R12: Halver divides by two, even duty
// R13: Modulus honoured over full twelve bits
// R14: Slip warning adds one cell, seven max
// R15: After overshoot cells drop one by one
// R16: Word three bit enables slip reduction
// R17: Host enables slip only with even duty; the bench enables it with the halver off
// R18: Mode 0,1 loads fast-lock timer
// R19: Wide bandwidth lasts timer-value comparison ticks
// R20: Host initialises once, then writes word three
// R21: Mode 0,0 off, 1,0 resync
// R22: Word select decoded, only that word updated
module sofc_top #(
  parameter int unsigned RCNT_W  = 10,
  parameter int unsigned TIMER_W = 12
) (
  input  logic                             hclk,
  input  logic                             hresetn,
  input  logic                             hsel,
  input  logic [31:0]                      haddr,
  input  logic [1:0]                       htrans,
  input  logic                             hwrite,
  input  logic [2:0]                       hsize,
  input  logic [31:0]                      hwdata,
  input  logic                             hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  input  logic                             ref_in,
  input  logic                             slip_warn_in,
  input  logic                             overshoot_in,
  output logic                             aux_sel,
  output logic                             aux_en,
  output logic [sofc_pkg::SOFC_PWR_W-1:0]  aux_pwr,
  output logic                             main_en,
  output logic [sofc_pkg::SOFC_PWR_W-1:0]  main_pwr,
  output logic [sofc_pkg::SOFC_DIV_W-1:0]  out_div_sel,
  output logic [sofc_pkg::SOFC_LDP_W-1:0]  lock_pin_mode,
  output logic [sofc_pkg::SOFC_INT_W-1:0]  int_factor,
  output logic [sofc_pkg::SOFC_FRACTION_NUMERATOR_W-1:0] fraction_numerator,
  output logic [sofc_pkg::SOFC_MOD_W-1:0]  fraction_modulus,
  output logic                             comparison_tick,
  output logic                             wide_bw,
  output logic                             resync_pulse,
  output logic [2:0]                       slip_cells
);
  import sofc_pkg::*;

  // ==========================================
  // Declarations
  logic [31:0]           words [0:SOFC_NUM_WORDS-1]; // Control word store
  logic [SOFC_NUM_WORDS-1:0] seen;    // Words written since reset
  logic [SOFC_SEL_W-1:0] last_sel;    // Select of last word taken
  logic                  addr_ok;     // Valid address phase
  logic                  wr_pend;     // Write data phase pending
  logic [7:0]            wr_addr;     // Captured write address
  logic                  wr_fire;     // Control word arrives now
  logic [SOFC_SEL_W-1:0] wsel;        // Select of arriving word
  logic                  wr_hit;      // Arriving word is mapped
  logic [31:0]           rd_mux;      // Read value for this address
  logic [2:0]            sync1;       // Pin synchroniser stage one
  logic [2:0]            sync2;       // Pin synchroniser stage two
  logic                  ref_d;       // Delayed reference level
  logic                  warn_d;      // Delayed slip warning level
  logic                  ref_edge;    // Active reference edge
  logic                  warn_evt;    // New slip warning
  logic [RCNT_W-1:0]     rcnt;        // Reference counter
  logic [RCNT_W-1:0]     ref_count;   // Programmed division
  logic                  r_tc;        // Reference counter terminal
  logic                  half_tog;    // Divide-by-two toggle
  logic                  doubler;     // Both reference edges active
  logic                  halver;      // Divide-by-two enabled
  logic                  slip_en;     // Slip reduction enabled
  logic                  resync_run;  // Resync timer running
  sofc_slip_state_t      slip_state;  // Slip controller state

  // ==========================================
  // AHB-Lite slave
  assign hreadyout = 1'b1;              // Zero wait states
  assign hresp     = SOFC_HRESP_OKAY;   // Always OKAY
  assign addr_ok   = hsel && hready && (htrans == SOFC_HTRANS_NONSEQ || htrans[1]);
  assign wr_fire   = wr_pend && (wr_addr == SOFC_ADDR_WORD);
  assign wsel      = sofc_sel(hwdata); // R22
  assign wr_hit    = wr_fire && (int'(wsel) < SOFC_NUM_WORDS); // R22

  // Capture address phase, register read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      hrdata  <= (addr_ok && !hwrite) ? rd_mux : 32'h0;
    end
  end

  // Read decode; unmapped reads zero
  always_comb begin
    rd_mux = 32'h0;
    if (haddr[7:0] == SOFC_ADDR_STATUS) begin
      rd_mux[SOFC_ST_WIDE]              = wide_bw;
      rd_mux[SOFC_ST_SYNC]              = resync_run;
      rd_mux[SOFC_ST_CELL +: 3]         = slip_cells;
      rd_mux[SOFC_ST_SEL +: SOFC_SEL_W] = last_sel;
    end else if (haddr[7:0] == SOFC_ADDR_SEEN) begin
      rd_mux[SOFC_NUM_WORDS-1:0] = seen;
    end else begin
      for (int i = 0; i < SOFC_NUM_WORDS; i++) begin
        if (haddr[7:0] == SOFC_ADDR_SHADOW + 8'(4 * i)) begin
          rd_mux = words[i];
        end
      end
    end
  end

  // ==========================================
  // Control word store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SOFC_NUM_WORDS; i++) begin
        words[i] <= 32'h0;
      end
      seen     <= '0;
      last_sel <= '0;
    end else if (wr_hit) begin
      // Only the addressed word changes
      words[wsel] <= hwdata; // R22
      seen[wsel]  <= 1'b1;
      last_sel    <= wsel;
    end
  end

  // ==========================================
  // Field outputs, straight from stored words
  assign aux_sel     = words[SOFC_IDX_OUT][SOFC_AUXS_BIT]; // R1
  assign aux_en      = words[SOFC_IDX_OUT][SOFC_AUXE_BIT]; // R2
  assign aux_pwr     = words[SOFC_IDX_OUT][SOFC_AUXP_LSB +: SOFC_PWR_W]; // R3
  assign main_en     = words[SOFC_IDX_OUT][SOFC_MAINE_BIT]; // R4
  assign main_pwr    = words[SOFC_IDX_OUT][SOFC_MAINP_LSB +: SOFC_PWR_W]; // R5
  assign out_div_sel = words[SOFC_IDX_OUT][SOFC_DIV_LSB +: SOFC_DIV_W]; // R9
  // Lock pin behaviour from word five
  assign lock_pin_mode      = words[SOFC_IDX_LOCK][SOFC_LDP_LSB +: SOFC_LDP_W]; // R6 R7
  assign int_factor         = words[SOFC_IDX_FREQ][SOFC_INT_LSB +: SOFC_INT_W]; // R9
  assign fraction_numerator = words[SOFC_IDX_FREQ][SOFC_FRACTION_NUMERATOR_LSB +: SOFC_FRACTION_NUMERATOR_W]; // R9
  // Any modulus value is passed on untouched
  assign fraction_modulus   = words[SOFC_IDX_MOD][SOFC_MOD_LSB +: SOFC_MOD_W]; // R13
  assign doubler   = words[SOFC_IDX_REF][SOFC_DBL_BIT];
  assign halver    = words[SOFC_IDX_REF][SOFC_HALF_BIT];
  assign ref_count = words[SOFC_IDX_REF][SOFC_RCNT_LSB +: RCNT_W];
  assign slip_en   = words[SOFC_IDX_CLK][SOFC_SLIP_BIT]; // R16

  // ==========================================
  // Pin synchronisers: ref, warning, overshoot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      ref_d  <= 1'b0;
      warn_d <= 1'b0;
    end else begin
      sync1  <= {overshoot_in, slip_warn_in, ref_in};
      sync2  <= sync1;
      ref_d  <= sync2[0];
      warn_d <= sync2[1];
    end
  end
  assign warn_evt = sync2[1] && !warn_d;

  // ==========================================
  // Comparison path: doubler, counter, halver
  // Falling edge only, or both edges when doubled
  assign ref_edge = doubler ? (sync2[0] != ref_d) : (ref_d && !sync2[0]); // R10
  // Count of zero acts as division by one
  assign r_tc = ref_edge && ((rcnt + RCNT_W'(1)) >= ref_count); // R10

  // Reference counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcnt <= '0;
    end else if (ref_edge) begin
      rcnt <= r_tc ? '0 : rcnt + RCNT_W'(1); // R10
    end
  end

  // Toggle halves the counter output for even duty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_tog        <= 1'b0;
      comparison_tick <= 1'b0;
    end else begin
      if (r_tc) begin
        half_tog <= !half_tog; // R12
      end
      comparison_tick <= r_tc && (!halver || half_tog); // R12
    end
  end

  // ==========================================
  // Fast-lock and resync timer
  sofc_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk        (hclk),
    .rstn       (hresetn),
    .load       (wr_hit && int'(wsel) == SOFC_IDX_CLK), // R18
    .mode       (sofc_cdiv_mode_t'(hwdata[SOFC_MODE_LSB +: SOFC_MODE_W])),
    .value      (hwdata[SOFC_CDIV_LSB +: TIMER_W]),
    .tick       (comparison_tick),
    .wide_bw    (wide_bw),
    .resync_run (resync_run),
    .sync_pulse (resync_pulse)
  );

  // ==========================================
  // Slip reduction: extra pump cells
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slip_state <= SOFC_SLIP_IDLE;
      slip_cells <= 3'h0;
    end else if (!slip_en) begin
      // Disabled: no extra cells
      slip_state <= SOFC_SLIP_IDLE;
      slip_cells <= 3'h0;
    end else begin
      case (slip_state)
        SOFC_SLIP_IDLE: begin
          // First warning switches on one cell
          if (warn_evt) begin
            slip_state <= SOFC_SLIP_BOOST;
            slip_cells <= 3'h1; // R14
          end
        end
        SOFC_SLIP_BOOST: begin
          // Overshoot starts the release
          if (sync2[2]) begin
            slip_state <= SOFC_SLIP_RELEASE; // R15
          end else if (warn_evt && slip_cells < SOFC_SLIP_MAX) begin
            slip_cells <= slip_cells + 3'h1; // R14
          end
        end
        SOFC_SLIP_RELEASE: begin
          // One cell off per comparison tick
          if (comparison_tick) begin
            slip_cells <= slip_cells - 3'h1; // R15
            if (slip_cells <= 3'h1) begin
              slip_state <= SOFC_SLIP_IDLE;
            end
          end
        end
        default: begin
          slip_state <= SOFC_SLIP_IDLE;
          slip_cells <= 3'h0;
        end
      endcase
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_WORD_STORE: assert property ( // R22
    wr_hit |=> words[$past(wsel)] == $past(hwdata))
    else $error("addressed control word not stored");
  AST_OTHER_KEEP: assert property ( // R22
    wr_fire && int'(wsel) != SOFC_IDX_OUT |=> $stable(main_pwr) && $stable(aux_pwr))
    else $error("output word changed by another select");
  AST_AUX_SEL: assert property ( // R1
    wr_fire && int'(wsel) == SOFC_IDX_OUT |=> aux_sel == $past(hwdata[SOFC_AUXS_BIT]))
    else $error("aux select not taken from its bit");
  AST_AUX_EN: assert property ( // R2
    wr_fire && int'(wsel) == SOFC_IDX_OUT |=> aux_en == $past(hwdata[SOFC_AUXE_BIT]))
    else $error("aux enable not taken from its bit");
  AST_AUX_PWR: assert property ( // R3
    wr_fire && int'(wsel) == SOFC_IDX_OUT
    |=> aux_pwr == $past(hwdata[SOFC_AUXP_LSB +: SOFC_PWR_W]))
    else $error("aux power not taken from its field");
  AST_MAIN_EN: assert property ( // R4
    wr_fire && int'(wsel) == SOFC_IDX_OUT |=> main_en == $past(hwdata[SOFC_MAINE_BIT]))
    else $error("primary enable not taken from its bit");
  AST_MAIN_PWR: assert property ( // R5
    wr_fire && int'(wsel) == SOFC_IDX_OUT
    |=> main_pwr == $past(hwdata[SOFC_MAINP_LSB +: SOFC_PWR_W]))
    else $error("primary power not taken from its field");
  AST_LOCK_PIN: assert property ( // R6
    wr_fire && int'(wsel) == SOFC_IDX_LOCK
    |=> lock_pin_mode == $past(hwdata[SOFC_LDP_LSB +: SOFC_LDP_W]))
    else $error("lock pin word not stored");
  AST_FAST_LOAD: assert property ( // R18
    wr_fire && int'(wsel) == SOFC_IDX_CLK
    && hwdata[SOFC_MODE_LSB +: SOFC_MODE_W] == SOFC_CDIV_FAST
    && hwdata[SOFC_CDIV_LSB +: TIMER_W] > TIMER_W'(1) |=> wide_bw [*2])
    else $error("fast-lock window not opened");
  AST_MODE_OFF: assert property ( // R21
    wr_fire && int'(wsel) == SOFC_IDX_CLK
    && hwdata[SOFC_MODE_LSB +: SOFC_MODE_W] == SOFC_CDIV_OFF |=> !wide_bw && !resync_run)
    else $error("divider off still runs the timer");
  AST_HALF_RATE: assert property ( // R12
    $past(halver) && comparison_tick |-> $past(half_tog) && !half_tog)
    else $error("halved tick not on every second count end");
  AST_SLIP_UP: assert property ( // R14
    slip_en && slip_state == SOFC_SLIP_BOOST && !sync2[2] && warn_evt
    && slip_cells < SOFC_SLIP_MAX |=> slip_cells == $past(slip_cells) + 3'h1)
    else $error("slip warning did not add a cell");
  AST_SLIP_DOWN: assert property ( // R15
    slip_en && slip_state == SOFC_SLIP_RELEASE && comparison_tick
    |=> slip_cells == $past(slip_cells) - 3'h1)
    else $error("release did not drop one cell");
  AST_SLIP_OFF: assert property ( // R16
    !slip_en |=> slip_cells == 3'h0 && slip_state == SOFC_SLIP_IDLE)
    else $error("extra cells active while disabled");

  COV_FAST: cover property (wr_hit ##1 $rose(wide_bw) ##[1:1000] $fell(wide_bw));
  COV_RESYNC: cover property (resync_pulse);
  COV_SLIP_MAX: cover property (slip_cells == SOFC_SLIP_MAX);
  COV_ALL_WORDS: cover property (&seen);

endmodule

// *** dv/sofc_host.sv ***
`timescale 1ns/1ps
// ==========================================
// Host controller model: AHB-Lite master writing control words
module sofc_host
  import sofc_pkg::*;
(
  input  logic        hclk,
  input  logic        hready,
  input  logic [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= SOFC_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released data lines show the inverse, not a stale copy
    hwdata <= ~d;
  endtask

  // Single word write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  // Single word read
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask
endmodule

// *** dv/synth_output_fastlock_config_tb.sv ***
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the synth output and fast-lock block
module synth_output_fastlock_config_tb;
  import sofc_pkg::*;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

  logic        hclk, hresetn, ref_in, slip_warn_in, overshoot_in;
  logic        hsel, hwrite, hreadyout, hresp, aux_sel, aux_en, main_en;
  logic        comparison_tick, wide_bw, resync_pulse;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans, aux_pwr, main_pwr, lock_pin_mode;
  logic [2:0]  hsize, out_div_sel, slip_cells, pc;
  logic [15:0] int_factor;
  logic [11:0] fraction_numerator, fraction_modulus;
  logic [31:0] shadow [6];             // Expected readback per word
  logic [31:0] init_w [6];             // Power-up words
  logic [11:0] mods [3];               // Modulus corner values
  int          n_fail, checked, cyc, n, k;

  sofc_host host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
                  .hsize, .hwdata);
  sofc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ref_in, .slip_warn_in,
                .overshoot_in, .aux_sel, .aux_en, .aux_pwr, .main_en, .main_pwr, .out_div_sel,
                .lock_pin_mode, .int_factor, .fraction_numerator, .fraction_modulus,
                .comparison_tick, .wide_bw, .resync_pulse, .slip_cells);

  // 100 MHz clock; reference of four clock periods
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    ref_in = 1'b0;
    forever #20 ref_in = ~ref_in;
  end

  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Control word write, remembering what readback should show
  task automatic put(input logic [31:0] w);
    host.wr({24'h0, SOFC_ADDR_WORD}, w);
    if (w[2:0] < 3'h6) shadow[w[2:0]] = w;
    repeat (2) @(posedge hclk);
  endtask

  // Cycles between two comparison ticks
  task automatic period(output int p);
    do @(posedge hclk); while (comparison_tick !== 1'b1);
    p = 0;
    do begin @(posedge hclk); p++; end while (comparison_tick !== 1'b1);
  endtask

  // One impending-slip event
  task automatic warn();
    slip_warn_in <= 1'b1;
    repeat (4) @(posedge hclk);
    slip_warn_in <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  // Output stage word and its pins
  task automatic outc(input logic s, ae, input logic [1:0] ap, input logic me,
                      input logic [1:0] mp, input logic [2:0] dv);
    put({9'h0, dv, 10'h0, s, ae, ap, me, mp, 3'h4});
    `CHK("aux_sel", s, aux_sel)
    `CHK("aux_en", ae, aux_en)
    `CHK("aux_pwr", ap, aux_pwr)
    `CHK("main_en", me, main_en)
    `CHK("main_pwr", mp, main_pwr)
    `CHK("out_div_sel", dv, out_div_sel)
  endtask

  initial begin
    hresetn = 1'b0; slip_warn_in = 1'b0; overshoot_in = 1'b0;
    n_fail = 0; checked = 0; cyc = 0; pc = 3'h7;
    init_w = '{{1'b0, 16'd422, 12'd13, 3'h0}, {17'h0, 12'd25, 3'h1},
               {6'h0, 1'b0, 1'b0, 10'd2, 11'h0, 3'h2}, {13'h0, 1'b0, 1'b0, 2'h0, 12'h0, 3'h3},
               {9'h0, 3'h1, 10'h0, 7'h0, 3'h4}, {8'h0, 2'h3, 19'h0, 3'h5}};
    mods = '{12'hfff, 12'h000, 12'h001};
    repeat (2) @(posedge hclk);
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("hresp", SOFC_HRESP_OKAY, hresp)
    hresetn <= 1'b1;
    @(posedge hclk);
    // Power-up order, words five down to zero; reference keeps rate low
    for (k = 5; k >= 0; k--) put(init_w[k]);
    `CHK("lock_pin_mode", 2'h3, lock_pin_mode)
    `CHK("int_factor", 16'd422, int_factor)
    `CHK("fraction_numerator", 12'd13, fraction_numerator)
    `CHK("fraction_modulus", 12'd25, fraction_modulus)
    foreach (mods[i]) begin
      put({17'h0, mods[i], 3'h1});
      `CHK("fraction_modulus", mods[i], fraction_modulus)
    end
    outc(1'b1, 1'b0, 2'h2, 1'b1, 2'h1, 3'h5);
    outc(1'b0, 1'b1, 2'h1, 1'b0, 2'h2, 3'h2);
    // Stray writes: wrong address, select six
    host.wr({24'h0, SOFC_ADDR_STATUS}, 32'h0000_03fc);
    put(32'h7fff_fffe);
    `CHK("aux_sel kept", 1'b0, aux_sel)
    `CHK("int_factor kept", 16'd422, int_factor)
    // Comparison period: plain, doubled, halved (halver gives even duty)
    for (k = 0; k < 3; k++) begin
      put({6'h0, k == 1, k == 2, 10'd2, 11'h0, 3'h2});
      period(n);
      period(n);
      `CHK("tick period", (k == 0) ? 8 : (k == 1) ? 4 : 16, n)
    end
    put({6'h0, 1'b0, 1'b0, 10'd2, 11'h0, 3'h2});
    // Fast lock for three comparison ticks
    // Count from the edge after the store, so no early tick is missed
    host.wr({24'h0, SOFC_ADDR_WORD}, {13'h0, 1'b0, 1'b0, 2'h1, 12'd3, 3'h3});
    n = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge hclk);
      if (k == 0) `CHK("wide_bw on", 1'b1, wide_bw)
      if (wide_bw === 1'b1 && comparison_tick === 1'b1) n++;
    end
    `CHK("wide ticks", 3, n)
    `CHK("wide_bw off", 1'b0, wide_bw)
    // Resync every two ticks, then divider off
    put({13'h0, 1'b0, 1'b0, 2'h2, 12'd2, 3'h3});
    do @(posedge hclk); while (resync_pulse !== 1'b1);
    n = 0;
    do begin @(posedge hclk); if (comparison_tick === 1'b1) n++; end
    while (resync_pulse !== 1'b1);
    `CHK("resync ticks", 2, n)
    `CHK("wide_bw resync", 1'b0, wide_bw)
    put({13'h0, 1'b0, 1'b0, 2'h0, 12'd2, 3'h3});
    n = 0;
    for (k = 0; k < 100; k++) begin @(posedge hclk); if (resync_pulse === 1'b1) n++; end
    `CHK("resync off", 0, n)
    // Slip reduction: build up to the cap, then release one by one
    put({13'h0, 1'b1, 1'b0, 2'h0, 12'd0, 3'h3});
    warn();
    `CHK("cells one", 3'h1, slip_cells)
    repeat (8) warn();
    `CHK("cells max", SOFC_SLIP_MAX, slip_cells)
    overshoot_in <= 1'b1;
    for (k = 0; k < 120; k++) begin
      @(posedge hclk);
      if (slip_cells !== pc) begin `CHK("cell step", pc - 3'h1, slip_cells) pc = slip_cells; end
    end
    `CHK("cells empty", 3'h0, slip_cells)
    overshoot_in <= 1'b0;
    warn();
    put({13'h0, 1'b0, 1'b0, 2'h0, 12'd0, 3'h3});
    `CHK("cells disabled", 3'h0, slip_cells)
    // Readback of every word and an unmapped place
    for (k = 0; k < 6; k++) begin
      host.rd({24'h0, SOFC_ADDR_SHADOW} + 32'(4 * k), rdv);
      `CHK("readback", shadow[k], rdv)
    end
    // All six words seen; last select three, timer and cells idle
    host.rd({24'h0, SOFC_ADDR_SEEN}, rdv);
    `CHK("seen", 32'h3f, rdv)
    host.rd({24'h0, SOFC_ADDR_STATUS}, rdv);
    `CHK("status", 32'h300, rdv)
    host.rd(32'h0000_0010, rdv);
    `CHK("unmapped", 32'h0, rdv)
    end_of_test();
  end
endmodule
